// File: pkg/ekic_pkg.sv
package ekic_pkg;
	// ---------------------------------------------------------------
	// Register map (byte addresses, one word each)
	// ---------------------------------------------------------------
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STAT_ADDR = 8'h04;
	localparam logic [7:0] KEYEN_ADDR = 8'h08;
	localparam logic [7:0] IRQST_ADDR = 8'h0C;
	localparam logic [7:0] IRQMSK_ADDR = 8'h10;
	localparam logic [7:0] PWR_ADDR = 8'h14;
	localparam logic [7:0] VEC_ADDR = 8'h18;
	// Control register fields
	localparam int CTL_A_EN = 7;
	localparam int CTL_B_EN = 6;
	localparam int CTL_KEY_EN = 4;
	localparam int CTL_A_EDGE = 3;
	localparam int CTL_B_EDGE = 2;
	localparam logic [7:0] CTL_IMPL = 8'hDC;
	// Status register fields
	localparam int ST_A_FLAG = 7;
	localparam int ST_B_FLAG = 6;
	localparam int ST_KEY_FLAG = 4;
	localparam int ST_A_CLR = 3;
	localparam int ST_B_CLR = 2;
	localparam int ST_KEY_CLR = 0;
	// Readable status bits; strobes and reserved bits read zero
	localparam logic [7:0] ST_FLAGS = 8'hD0;
	// Sticky event bits: 0 ext a, 1 ext b, 2 key, 3 wake
	localparam int EV_W = 4;
	localparam int PWR_STOP = 0;
	localparam int PWR_WAIT = 1;
	// Vector addresses
	localparam logic [15:0] VEC_TB_HI = 16'hFFF0;
	localparam logic [15:0] VEC_TB_LO = 16'hFFF1;
	localparam logic [15:0] VEC_SER_HI = 16'hFFF2;
	localparam logic [15:0] VEC_SER_LO = 16'hFFF3;
	localparam logic [15:0] VEC_EXT_HI = 16'hFFFA;
	localparam logic [15:0] VEC_EXT_LO = 16'hFFFB;
	// Block state
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] key_input_enable_reg;
		logic ext_req_a_flag;
		logic ext_req_b_flag;
		logic key_wake_flag;
		logic [7:0] key_latch;
		logic [1:0] ext_s1;
		logic [1:0] ext_s2;
		logic [1:0] ext_prev;
		logic [7:0] key_s1;
		logic [7:0] key_s2;
		logic [7:0] key_prev;
		logic [EV_W-1:0] irq_status;
		logic [EV_W-1:0] irq_mask;
		logic stop_mode;
		logic wait_mode;
		logic [31:0] prdata;
	} ekic_state_t;
endpackage : ekic_pkg

// File: core/ekic_top.sv
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
// Contract
// - Serial transfer done vector fetched from FFF2 high, FFF3 low.
// - Timebase vector fetched from FFF0 high, FFF1 low.
// - Each external line has an enable; zero blocks; reset clears both.
// - Key wake enable passes or blocks key wake flag; reset clears it.
// - Sensitivity bit: 0 edge plus low level, 1 falling edge only.
// - Control bit 5 and bits 1,0 read as zero.
// - External flag set per sensitivity; interrupt when flag and enable set.
// - External flags read-only; cleared by writing one to clear bit or reset.
// - Key flag set by falling edge on enabled key; interrupt when enabled.
// - Key flag read-only; writing one to clear bit clears, zero ignored.
// - Clear bits are write-only, read zero; writing zero does nothing.
// - Status bits 5 and 1 read as zero.
// - Stop mode ends only on reset or listed wake sources.
// - Entering stop clears global mask and timer prescaler.
// - Wait mode ends on any interrupt or reset; entry clears global mask. Here serial_slave_irq does not end wait.
// - One falling-edge latch per key; flag clear clears all latches.
// - External lines share vector FFFA/FFFB; masked requests stay pending.
module ekic_top (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins
	input wire logic ext_req_a_n,
	input wire logic ext_req_b_n,
	input wire logic [7:0] key_input_n,
	// CPU side
	input wire logic global_mask,
	input wire logic enter_stop,
	input wire logic enter_wait,
	input wire logic serial_slave_irq,
	input wire logic serial_irq,
	input wire logic timebase_irq,
	input wire logic other_irq,
	output logic ext_irq_req,
	output logic key_wake_interrupt,
	output logic [15:0] ext_vector_hi,
	output logic [15:0] ext_vector_lo,
	output logic [15:0] serial_vector_hi,
	output logic [15:0] serial_vector_lo,
	output logic [15:0] timebase_vector_hi,
	output logic [15:0] timebase_vector_lo,
	output logic global_mask_clear,
	output logic prescaler_clear,
	output logic stop_mode,
	output logic wait_mode,
	output logic wake,
	output logic irq
);
	ekic_pkg::ekic_state_t st_reg, st_next;
	logic wr, rd, mapped;
	logic [1:0] ext_fall, ext_low, ext_set, ext_clr;
	logic [7:0] key_fall;
	logic key_set, key_clr, wake_ev, ext_pend, key_pend;

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	// Zero wait states keep the slave simple; pready stays high
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~pwrite;
	assign mapped = paddr <= ekic_pkg::VEC_ADDR && paddr[1:0] == 2'h0;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// ---------------------------------------------------------------
	// Event detection
	// ---------------------------------------------------------------
	// Only the second synchroniser stage and the history are read
	assign ext_fall = st_reg.ext_prev & ~st_reg.ext_s2;
	assign ext_low = ~st_reg.ext_s2;
	assign ext_set[0] = st_reg.ctrl[ekic_pkg::CTL_A_EDGE] ? ext_fall[0] : ext_low[0];
	assign ext_set[1] = st_reg.ctrl[ekic_pkg::CTL_B_EDGE] ? ext_fall[1] : ext_low[1];
	assign ext_clr[0] = wr && paddr == ekic_pkg::STAT_ADDR && pwdata[ekic_pkg::ST_A_CLR];
	assign ext_clr[1] = wr && paddr == ekic_pkg::STAT_ADDR && pwdata[ekic_pkg::ST_B_CLR];
	assign key_clr = wr && paddr == ekic_pkg::STAT_ADDR && pwdata[ekic_pkg::ST_KEY_CLR];
	assign key_fall = st_reg.key_prev & ~st_reg.key_s2 & st_reg.key_input_enable_reg;
	assign key_set = |key_fall;

	// Requests to the CPU; global mask only holds them off, flags stay pending
	assign ext_pend = (st_reg.ext_req_a_flag & st_reg.ctrl[ekic_pkg::CTL_A_EN])
		| (st_reg.ext_req_b_flag & st_reg.ctrl[ekic_pkg::CTL_B_EN]);
	assign key_pend = st_reg.key_wake_flag & st_reg.ctrl[ekic_pkg::CTL_KEY_EN];
	assign ext_irq_req = ext_pend & ~global_mask;
	assign key_wake_interrupt = key_pend & ~global_mask;
	// Stop wakes only on the listed sources; wait wakes on any except serial_slave_irq
	assign wake_ev = (st_reg.stop_mode & (ext_pend | key_pend | serial_slave_irq
		| timebase_irq))
		| (st_reg.wait_mode & (ext_pend | key_pend | serial_irq | timebase_irq
		| other_irq));

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.ext_s1 = {~ext_req_b_n, ~ext_req_a_n} ^ 2'h3;
		st_next.ext_s2 = st_reg.ext_s1;
		st_next.ext_prev = st_reg.ext_s2;
		st_next.key_s1 = key_input_n;
		st_next.key_s2 = st_reg.key_s1;
		st_next.key_prev = st_reg.key_s2;
		// Clear first, set afterwards so a coincident event survives
		if (ext_clr[0])
			st_next.ext_req_a_flag = 1'b0;
		if (ext_clr[1])
			st_next.ext_req_b_flag = 1'b0;
		if (ext_set[0])
			st_next.ext_req_a_flag = 1'b1;
		if (ext_set[1])
			st_next.ext_req_b_flag = 1'b1;
		if (key_clr) begin
			st_next.key_wake_flag = 1'b0;
			st_next.key_latch = 8'h00;
		end
		st_next.key_latch = st_next.key_latch | key_fall;
		if (key_set)
			st_next.key_wake_flag = 1'b1;
		// Low-power modes
		if (wake_ev) begin
			st_next.stop_mode = 1'b0;
			st_next.wait_mode = 1'b0;
		end else if (enter_stop) begin
			st_next.stop_mode = 1'b1;
		end else if (enter_wait) begin
			st_next.wait_mode = 1'b1;
		end
		// Register writes
		if (wr) begin
			unique case (paddr)
				ekic_pkg::CTRL_ADDR: st_next.ctrl = pwdata[7:0] & ekic_pkg::CTL_IMPL;
				ekic_pkg::KEYEN_ADDR: st_next.key_input_enable_reg = pwdata[7:0];
				ekic_pkg::IRQMSK_ADDR: st_next.irq_mask = pwdata[ekic_pkg::EV_W-1:0];
				default: ;
			endcase
		end
		// Sticky status: write one clears, new events win
		if (wr && paddr == ekic_pkg::IRQST_ADDR)
			st_next.irq_status = st_reg.irq_status & ~pwdata[ekic_pkg::EV_W-1:0];
		st_next.irq_status = st_next.irq_status
			| {wake_ev, key_set, ext_set[1], ext_set[0]};
		// Read data
		st_next.prdata = 32'h0000_0000;
		if (rd) begin
			unique case (paddr)
				ekic_pkg::CTRL_ADDR: st_next.prdata[7:0] = st_reg.ctrl & ekic_pkg::CTL_IMPL;
				ekic_pkg::STAT_ADDR: begin
					// Clear bits and reserved bits read as zero
					st_next.prdata[ekic_pkg::ST_A_FLAG] = st_reg.ext_req_a_flag;
					st_next.prdata[ekic_pkg::ST_B_FLAG] = st_reg.ext_req_b_flag;
					st_next.prdata[ekic_pkg::ST_KEY_FLAG] = st_reg.key_wake_flag;
				end
				ekic_pkg::KEYEN_ADDR: st_next.prdata[7:0] = st_reg.key_input_enable_reg;
				ekic_pkg::IRQST_ADDR: st_next.prdata[ekic_pkg::EV_W-1:0] = st_reg.irq_status;
				ekic_pkg::IRQMSK_ADDR: st_next.prdata[ekic_pkg::EV_W-1:0] = st_reg.irq_mask;
				ekic_pkg::PWR_ADDR: begin
					st_next.prdata[ekic_pkg::PWR_STOP] = st_reg.stop_mode;
					st_next.prdata[ekic_pkg::PWR_WAIT] = st_reg.wait_mode;
				end
				ekic_pkg::VEC_ADDR: st_next.prdata[15:0] = ekic_pkg::VEC_EXT_HI;
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.ext_s1 <= '1; // Pins idle high, so no false edge after reset
			st_reg.ext_s2 <= '1;
			st_reg.ext_prev <= '1;
			st_reg.key_s1 <= '1;
			st_reg.key_s2 <= '1;
			st_reg.key_prev <= '1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign prdata = st_reg.prdata;
	assign ext_vector_hi = ekic_pkg::VEC_EXT_HI;
	assign ext_vector_lo = ekic_pkg::VEC_EXT_LO;
	assign serial_vector_hi = ekic_pkg::VEC_SER_HI;
	assign serial_vector_lo = ekic_pkg::VEC_SER_LO;
	assign timebase_vector_hi = ekic_pkg::VEC_TB_HI;
	assign timebase_vector_lo = ekic_pkg::VEC_TB_LO;
	// Entry pulses drop the CPU mask; stop entry also resets the prescaler
	assign global_mask_clear = (enter_stop | enter_wait) & ~wake_ev;
	assign prescaler_clear = enter_stop & ~wake_ev;
	assign stop_mode = st_reg.stop_mode;
	assign wait_mode = st_reg.wait_mode;
	assign wake = wake_ev;
	assign irq = |(st_reg.irq_status & st_reg.irq_mask);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_ena_gate;
		@(posedge pclk) disable iff (!presetn)
		ext_irq_req |-> ((st_reg.ext_req_a_flag && st_reg.ctrl[ekic_pkg::CTL_A_EN])
			|| (st_reg.ext_req_b_flag && st_reg.ctrl[ekic_pkg::CTL_B_EN]));
	endproperty
	a_ena_gate: assert property (p_ena_gate) else $error("ext request without enable");

	property p_key_gate;
		@(posedge pclk) disable iff (!presetn)
		key_wake_interrupt
			== (st_reg.key_wake_flag && st_reg.ctrl[ekic_pkg::CTL_KEY_EN] && !global_mask);
	endproperty
	a_key_gate: assert property (p_key_gate) else $error("key interrupt gating wrong");

	property p_level_set;
		@(posedge pclk) disable iff (!presetn)
		(!st_reg.ctrl[ekic_pkg::CTL_A_EDGE] && !st_reg.ext_s2[0]) |=> st_reg.ext_req_a_flag;
	endproperty
	a_level_set: assert property (p_level_set) else $error("low level did not set flag");

	property p_ctrl_rsv;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.ctrl & ~ekic_pkg::CTL_IMPL) == 8'h00;
	endproperty
	a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("reserved control bit set");

	property p_clear_a;
		@(posedge pclk) disable iff (!presetn)
		(ext_clr[0] && !ext_set[0]) |=> !st_reg.ext_req_a_flag;
	endproperty
	a_clear_a: assert property (p_clear_a) else $error("flag a not cleared");

	property p_key_set;
		@(posedge pclk) disable iff (!presetn)
		key_set |=> st_reg.key_wake_flag && st_reg.key_latch != 8'h00;
	endproperty
	a_key_set: assert property (p_key_set) else $error("key edge lost");

	property p_key_hold;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.key_wake_flag && !key_clr) |=> st_reg.key_wake_flag;
	endproperty
	a_key_hold: assert property (p_key_hold) else $error("key flag dropped");

	property p_stat_read;
		@(posedge pclk) disable iff (!presetn)
		(rd && paddr == ekic_pkg::STAT_ADDR)
			|=> ((prdata & ~{24'h00_0000, ekic_pkg::ST_FLAGS}) == 32'h0000_0000);
	endproperty
	a_stat_read: assert property (p_stat_read) else $error("status zero bits read one");

	property p_stop_wake;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.stop_mode && !ext_pend && !key_pend && !serial_slave_irq && !timebase_irq)
			|=> st_reg.stop_mode;
	endproperty
	a_stop_wake: assert property (p_stop_wake) else $error("stop left without cause");

	property p_race;
		@(posedge pclk) disable iff (!presetn)
		(ext_set[0] && ext_clr[0]) |=> st_reg.ext_req_a_flag;
	endproperty
	a_race: assert property (p_race) else $error("event lost to clear");

	// Edge-only line a ignores a pin that stays low
	property p_edge_only_a;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.ctrl[ekic_pkg::CTL_A_EDGE] && !st_reg.ext_req_a_flag && !ext_fall[0])
			|=> !st_reg.ext_req_a_flag;
	endproperty
	a_edge_only_a: assert property (p_edge_only_a) else $error("flag a set without edge");

	// Edge-only line b ignores a pin that stays low
	property p_edge_only_b;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.ctrl[ekic_pkg::CTL_B_EDGE] && !st_reg.ext_req_b_flag && !ext_fall[1])
			|=> !st_reg.ext_req_b_flag;
	endproperty
	a_edge_only_b: assert property (p_edge_only_b) else $error("flag b set without edge");

	// A pending flag a waits for its clear strobe, masked or not
	property p_hold_a;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.ext_req_a_flag && !ext_clr[0]) |=> st_reg.ext_req_a_flag;
	endproperty
	a_hold_a: assert property (p_hold_a) else $error("flag a dropped");

	// Flag b only falls on its strobe
	property p_hold_b;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.ext_req_b_flag && !ext_clr[1]) |=> st_reg.ext_req_b_flag;
	endproperty
	a_hold_b: assert property (p_hold_b) else $error("flag b dropped");

	// Strobe clears flag b when no event competes
	property p_clear_b;
		@(posedge pclk) disable iff (!presetn)
		(ext_clr[1] && !ext_set[1]) |=> !st_reg.ext_req_b_flag;
	endproperty
	a_clear_b: assert property (p_clear_b) else $error("flag b not cleared");

	// Key clear drops the flag and every edge latch together
	property p_key_clear;
		@(posedge pclk) disable iff (!presetn)
		(key_clr && !key_set) |=> (!st_reg.key_wake_flag && st_reg.key_latch == 8'h00);
	endproperty
	a_key_clear: assert property (p_key_clear) else $error("key clear incomplete");

	// No enabled key edge, no key flag
	property p_key_quiet;
		@(posedge pclk) disable iff (!presetn)
		(!st_reg.key_wake_flag && !key_set) |=> !st_reg.key_wake_flag;
	endproperty
	a_key_quiet: assert property (p_key_quiet) else $error("key flag without edge");

	// Each enabled key edge lands in its own latch
	property p_key_latch;
		@(posedge pclk) disable iff (!presetn)
		(key_fall != 8'h00) |=> ((st_reg.key_latch & $past(key_fall)) == $past(key_fall));
	endproperty
	a_key_latch: assert property (p_key_latch) else $error("key latch missed edge");

	// Control readback shows only implemented bits
	property p_ctrl_read;
		@(posedge pclk) disable iff (!presetn)
		(rd && paddr == ekic_pkg::CTRL_ADDR)
			|=> ((prdata & ~{24'h00_0000, ekic_pkg::CTL_IMPL}) == 32'h0000_0000);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control reserved bit read one");

	// Stop entry drops the CPU mask and the prescaler, then holds stop
	property p_stop_entry;
		@(posedge pclk) disable iff (!presetn)
		(enter_stop && !wake_ev)
			|-> (global_mask_clear && prescaler_clear) ##1 st_reg.stop_mode;
	endproperty
	a_stop_entry: assert property (p_stop_entry) else $error("stop entry wrong");

	// Wait entry drops the CPU mask, then holds wait
	property p_wait_entry;
		@(posedge pclk) disable iff (!presetn)
		(enter_wait && !enter_stop && !wake_ev) |-> global_mask_clear ##1 st_reg.wait_mode;
	endproperty
	a_wait_entry: assert property (p_wait_entry) else $error("wait entry wrong");

	// Any listed source ends stop on the next edge
	property p_stop_exit;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.stop_mode && (ext_pend || key_pend || serial_slave_irq || timebase_irq))
			|=> !st_reg.stop_mode;
	endproperty
	a_stop_exit: assert property (p_stop_exit) else $error("stop not left on wake source");

	// Any interrupt except serial_slave_irq ends wait on the next edge
	property p_wait_exit;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.wait_mode && (ext_pend || key_pend || serial_irq || timebase_irq || other_irq))
			|=> !st_reg.wait_mode;
	endproperty
	a_wait_exit: assert property (p_wait_exit) else $error("wait not left on interrupt");

	// The CPU mask holds both requests off
	property p_mask_off;
		@(posedge pclk) disable iff (!presetn)
		global_mask |-> (!ext_irq_req && !key_wake_interrupt);
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("request while masked");

	// Enabled flag a reaches the CPU when unmasked
	property p_a_reaches;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.ext_req_a_flag && st_reg.ctrl[ekic_pkg::CTL_A_EN] && !global_mask) |-> ext_irq_req;
	endproperty
	a_a_reaches: assert property (p_a_reaches) else $error("flag a request missing");

	// Both enables low block every external request
	property p_ext_blocked;
		@(posedge pclk) disable iff (!presetn)
		(!st_reg.ctrl[ekic_pkg::CTL_A_EN] && !st_reg.ctrl[ekic_pkg::CTL_B_EN]) |-> !ext_irq_req;
	endproperty
	a_ext_blocked: assert property (p_ext_blocked) else $error("request while disabled");
endmodule : ekic_top

// File: dv/ekic_pin_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Pin side: request lines and keypad, pulled up when idle
// ---------------------------------------------------------------
module ekic_pin_model (
	// Bench commands
	input wire logic press_a,
	input wire logic press_b,
	input wire logic [7:0] key_press,
	// Active-low pins
	output logic ext_req_a_n,
	output logic ext_req_b_n,
	output logic [7:0] key_input_n
);
	// A released pin goes back to its pull-up level, never a stale low
	assign ext_req_a_n = ~press_a;
	assign ext_req_b_n = ~press_b;
	assign key_input_n = ~key_press;
endmodule : ekic_pin_model

// File: dv/test_ext_key_interrupt_ctrl.sv
`timescale 1ns/1ps
module test_ext_key_interrupt_ctrl;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, key_input_n, key_press;
	logic [31:0] pwdata, prdata, rd, seed;
	logic ext_req_a_n, ext_req_b_n, press_a, press_b, global_mask;
	logic enter_stop, enter_wait, timebase_irq, other_irq, serial_slave_irq, serial_irq;
	logic ext_irq_req, key_wake_interrupt, gm_clr, ps_clr, stop_mode, wait_mode, wake, irq;
	logic [15:0] evh, evl, svh, svl, tvh, tvl;
	int bad_count, comparisons, cycles;

	// Clock, 40 ns period
	initial pclk = 1'b0;
	always #20 pclk = ~pclk;

	ekic_pin_model pins (.press_a(press_a), .press_b(press_b), .key_press(key_press),
		.ext_req_a_n(ext_req_a_n), .ext_req_b_n(ext_req_b_n), .key_input_n(key_input_n));

	ekic_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_req_a_n(ext_req_a_n), .ext_req_b_n(ext_req_b_n),
		.key_input_n(key_input_n), .global_mask(global_mask), .enter_stop(enter_stop),
		.enter_wait(enter_wait), .serial_slave_irq(serial_slave_irq), .serial_irq(serial_irq),
		.timebase_irq(timebase_irq), .other_irq(other_irq), .ext_irq_req(ext_irq_req),
		.key_wake_interrupt(key_wake_interrupt), .ext_vector_hi(evh), .ext_vector_lo(evl),
		.serial_vector_hi(svh), .serial_vector_lo(svl), .timebase_vector_hi(tvh),
		.timebase_vector_lo(tvl), .global_mask_clear(gm_clr), .prescaler_clear(ps_clr),
		.stop_mode(stop_mode), .wait_mode(wait_mode), .wake(wake), .irq(irq));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Control readback: bit 5 and bits 1,0 read as zero
	function automatic logic [31:0] exp_ctrl(input logic [7:0] d);
		return {24'h0, d & 8'hDC};
	endfunction : exp_ctrl

	task chk(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick

	// One APB transfer; data and error taken at the edge that sees pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		// One idle edge, so a following call never reassigns psel in this step
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task close_out;
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : close_out

	// Hang guard, well above the length of the sequence
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			close_out;
		end
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{press_a, press_b, key_press, global_mask, enter_stop, enter_wait} = '0;
		{timebase_irq, other_irq, serial_slave_irq, serial_irq} = '0;
		seed = 32'h2B1C3DCF;
		tick(3);
		presetn <= 1'b1;
		apb(1'b0, ekic_pkg::CTRL_ADDR, 32'h0);
		chk(rd, 32'h0);
		chk({evh, evl}, 32'hFFFAFFFB);
		chk({svh, svl}, 32'hFFF2FFF3);
		chk({tvh, tvl}, 32'hFFF0FFF1);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			apb(1'b1, ekic_pkg::CTRL_ADDR, seed);
			apb(1'b0, ekic_pkg::CTRL_ADDR, 32'h0);
			chk(rd, exp_ctrl(seed[7:0]));
		end
		// Line a, edge only, then level mode where a held pin re-sets
		apb(1'b1, ekic_pkg::CTRL_ADDR, 32'h88);
		press_a <= 1'b1;
		tick(6);
		apb(1'b0, ekic_pkg::STAT_ADDR, 32'h0);
		chk(rd, 32'h80);
		chk(ext_irq_req, 1'b1);
		global_mask <= 1'b1;
		tick(2);
		chk(ext_irq_req, 1'b0);
		global_mask <= 1'b0;
		tick(1);
		chk(ext_irq_req, 1'b1);
		apb(1'b1, ekic_pkg::STAT_ADDR, 32'h08);
		apb(1'b0, ekic_pkg::STAT_ADDR, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, ekic_pkg::CTRL_ADDR, 32'h80);
		apb(1'b1, ekic_pkg::STAT_ADDR, 32'h08);
		apb(1'b0, ekic_pkg::STAT_ADDR, 32'h0);
		chk(rd, 32'h80);
		press_a <= 1'b0;
		tick(4);
		apb(1'b1, ekic_pkg::STAT_ADDR, 32'h08);
		// Line b flags while its enable blocks the request
		apb(1'b1, ekic_pkg::CTRL_ADDR, 32'h04);
		press_b <= 1'b1;
		tick(6);
		chk(ext_irq_req, 1'b0);
		apb(1'b0, ekic_pkg::STAT_ADDR, 32'h0);
		chk(rd, 32'h40);
		apb(1'b1, ekic_pkg::STAT_ADDR, 32'h04);
		press_b <= 1'b0;
		tick(4);
		// Sticky events: unmasked, masked, cleared
		apb(1'b1, ekic_pkg::IRQMSK_ADDR, 32'h1);
		tick(1);
		chk(irq, 1'b1);
		apb(1'b1, ekic_pkg::IRQMSK_ADDR, 32'h0);
		tick(1);
		chk(irq, 1'b0);
		apb(1'b1, ekic_pkg::IRQST_ADDR, 32'hF);
		apb(1'b0, ekic_pkg::IRQST_ADDR, 32'h0);
		chk(rd, 32'h0);
		// Keys: a disabled key is ignored, an enabled one latches
		seed = lfsr(seed);
		apb(1'b1, ekic_pkg::KEYEN_ADDR, {24'h0, seed[7:2], 2'b01});
		apb(1'b1, ekic_pkg::CTRL_ADDR, 32'h10);
		key_press <= 8'h02;
		tick(6);
		apb(1'b0, ekic_pkg::STAT_ADDR, 32'h0);
		chk(rd, 32'h0);
		key_press <= 8'h03;
		tick(6);
		apb(1'b0, ekic_pkg::STAT_ADDR, 32'h0);
		chk(rd, 32'h10);
		chk(key_wake_interrupt, 1'b1);
		apb(1'b1, ekic_pkg::STAT_ADDR, 32'h0);
		apb(1'b0, ekic_pkg::STAT_ADDR, 32'h0);
		chk(rd, 32'h10);
		apb(1'b1, ekic_pkg::STAT_ADDR, 32'h01);
		apb(1'b0, ekic_pkg::STAT_ADDR, 32'h0);
		chk(rd, 32'h0);
		key_press <= 8'h00;
		tick(4);
		// Stop: an unlisted source must not wake, a key must
		other_irq <= 1'b1;
		serial_irq <= 1'b1;
		enter_stop <= 1'b1;
		@(negedge pclk);
		chk({gm_clr, ps_clr}, 2'b11);
		@(posedge pclk);
		enter_stop <= 1'b0;
		tick(4);
		chk(stop_mode, 1'b1);
		key_press <= 8'h01;
		tick(8);
		chk(stop_mode, 1'b0);
		other_irq <= 1'b0;
		serial_irq <= 1'b0;
		key_press <= 8'h00;
		apb(1'b1, ekic_pkg::STAT_ADDR, 32'h01);
		// Second stop, left on a serial slave interrupt
		enter_stop <= 1'b1;
		@(posedge pclk);
		enter_stop <= 1'b0;
		tick(2);
		chk(stop_mode, 1'b1);
		serial_slave_irq <= 1'b1;
		tick(2);
		chk(stop_mode, 1'b0);
		serial_slave_irq <= 1'b0;
		// Wait: left on a timebase interrupt
		enter_wait <= 1'b1;
		@(negedge pclk);
		chk(gm_clr, 1'b1);
		@(posedge pclk);
		enter_wait <= 1'b0;
		tick(3);
		chk(wait_mode, 1'b1);
		timebase_irq <= 1'b1;
		@(negedge pclk);
		chk(wake, 1'b1);
		tick(4);
		chk(wait_mode, 1'b0);
		timebase_irq <= 1'b0;
		apb(1'b0, 8'h40, 32'h0);
		chk({err, rd}, {1'b1, 32'h0});
		// Second reset in mid-run
		apb(1'b1, ekic_pkg::CTRL_ADDR, 32'hD0);
		presetn <= 1'b0;
		tick(2);
		presetn <= 1'b1;
		apb(1'b0, ekic_pkg::CTRL_ADDR, 32'h0);
		chk(rd, 32'h0);
		close_out;
	end
endmodule : test_ext_key_interrupt_ctrl
